// [verilog/sfpi_cfg.svh]
`ifndef SFPI_CFG_SVH
`define SFPI_CFG_SVH

// ==========================================================================
// Instruction codes
`define SFPI_OP_READ        8'h03
`define SFPI_OP_DUAL_READ   8'h3B
`define SFPI_OP_QUAD_READ   8'h6B
`define SFPI_OP_PROG        8'h02
`define SFPI_OP_QUAD_PROG   8'h32
`define SFPI_OP_ERASE_4K    8'h20
`define SFPI_OP_ERASE_32K   8'h52
`define SFPI_OP_ERASE_64K   8'hD8
`define SFPI_OP_ERASE_CHIP  8'hC7
`define SFPI_OP_WR_STATUS   8'h01
`define SFPI_OP_FOUR_ON     8'h38
`define SFPI_OP_FOUR_OFF    8'hFF

// ==========================================================================
// Array organisation
`define SFPI_PAGE_BYTES     9'h100
`define SFPI_MASK_4K        21'h1FF000
`define SFPI_MASK_32K       21'h1F8000
`define SFPI_MASK_64K       21'h1F0000
`define SFPI_MASK_CHIP      21'h000000

// ==========================================================================
// Shifter counts and fill value
`define SFPI_BYTE_BITS      5'h08
`define SFPI_ADDR_BITS      5'h18
`define SFPI_RD_FILL        8'hFF

`endif

// [verilog/sfpi_pkg.sv]
package sfpi_pkg;

  typedef enum logic [3:0] {
    K_READ, K_PROG, K_ERASE_4K, K_ERASE_32K, K_ERASE_64K, K_ERASE_CHIP,
    K_WR_STATUS, K_MODE_ON, K_MODE_OFF, K_OTHER
  } sfpi_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_IGNORE
  } sfpi_state_t;

  typedef struct packed {
    sfpi_kind_t  kind;
    logic [7:0]  opcode;
    logic [20:0] addr;
    logic [2:0]  lanes;
  } sfpi_cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] clear_mask;
    logic [7:0] offset;
  } sfpi_wr_t;

  typedef struct packed {
    sfpi_kind_t kind;
    logic [2:0] lanes;
    logic       has_addr;
    logic       legal;
  } sfpi_dec_t;

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic [3:0] io;
  } sfpi_pins_t;

endpackage : sfpi_pkg

// [verilog/sfpi_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module sfpi_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Asynchronous level in, synchronised level out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_ff
);

  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

endmodule : sfpi_sync

`default_nettype wire

// [verilog/sfpi_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module sfpi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Filling side.
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready_ff,
  // Draining side; data come from a register.
  output logic      [WIDTH-1:0] out_data_ff,
  output logic                  out_valid_ff,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_ff, rptr_ff, nxt_wptr, nxt_rptr;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             nxt_in_ready, nxt_out_valid, push, load;

  // The output stage refills from the store whenever it empties, so the
  // store plus the stage together hold DEPTH + 1 words.
  always_comb begin
    push          = in_valid & in_ready_ff;
    load          = (cnt_ff != '0) & (~out_valid_ff | out_ready);
    nxt_wptr      = push ? AW'(wptr_ff + 1'b1) : wptr_ff;
    nxt_rptr      = load ? AW'(rptr_ff + 1'b1) : rptr_ff;
    nxt_cnt       = cnt_ff + (AW+1)'(push) - (AW+1)'(load);
    nxt_in_ready  = nxt_cnt != (AW+1)'(DEPTH);
    nxt_out_valid = load | (out_valid_ff & ~out_ready);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wptr_ff      <= '0;
      rptr_ff      <= '0;
      cnt_ff       <= '0;
      in_ready_ff  <= 1'b1;
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else begin
      wptr_ff      <= nxt_wptr;
      rptr_ff      <= nxt_rptr;
      cnt_ff       <= nxt_cnt;
      in_ready_ff  <= nxt_in_ready;
      out_valid_ff <= nxt_out_valid;
      if (load) begin
        out_data_ff <= mem[rptr_ff];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wptr_ff] <= in_data;
    end
  end

endmodule : sfpi_fifo

`default_nettype wire

// [verilog/sfpi_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sfpi_cfg.svh"
// Overview of operation
// - Single lane: serial_in sampled for instruction, address, data on rise.
// - Single lane: read data leaves on io lane 1, changing on clock fall.
// - Multi-lane: host drives lanes on rise, device drives read data on fall.
// - Quad and four-lane instructions need quad_enable_bit set.
// - With quad_enable_bit set, write protect becomes lane 2, pause lane 3.
// - Chip select high: deselected, every io lane released.
// - Started erase, program or status write survives chip select going high.
// - Chip select low: selected, takes instructions, supplies read data.
// - Instructions start after a high-to-low chip select; the synchroniser resets high, so chip select held low through reset also starts one.
// - Pause low while selected: outputs released, input and clock ignored.
// - Pause released while selected: operation resumes from the held state.
// - No pause function while quad_enable_bit is set.
// - Asserted write protect plus protect bits blocks status register writes.
// - No write-protect function while quad_enable_bit is set.
// - 8,192 pages of 256 bytes; one program writes at most one page.
// - Programming only clears bits; setting bits needs an erase.
// - Erase covers 4KB sector, 32KB block, 64KB block or whole chip.
// - 512 sectors, 64 and 32 blocks, each aligned on its size.
// - Addresses 000000h to 1FFFFFh; sectors span 1000h-aligned ranges.
// - Clock modes 0 and 3 both work; only clock edges matter.
// - Pause starts and ends at pin edge if clock low, else next fall.

module sfpi_top #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset.
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // Flash pins.
  input  wire logic               sclk,
  input  wire logic               cs_n,
  input  wire logic [3:0]         io_in,
  output logic      [3:0]         io_out_ff,
  output logic      [3:0]         io_oe_ff,
  // Configuration.
  input  wire logic               quad_enable_bit,
  input  wire logic [1:0]         status_protect_bits,
  // Command hand-off.
  output var sfpi_pkg::sfpi_cmd_t cmd_ff,
  output logic                    cmd_valid_ff,
  input  wire logic               cmd_ready,
  // Write data.
  output var sfpi_pkg::sfpi_wr_t  wr_ff,
  output logic                    wr_valid_ff,
  // Read data.
  input  wire logic [7:0]         rd_data,
  input  wire logic               rd_valid,
  output logic                    rd_ready_ff,
  // Status.
  output logic                    selected_ff,
  output logic                    paused_ff,
  output logic                    four_lane_command_mode_ff,
  output logic                    status_write_blocked_ff
);
  import sfpi_pkg::*;

  // ========================================================================
  // Helpers
  function automatic sfpi_dec_t f_decode(input logic [7:0] op,
                                         input logic qe, input logic four);
    sfpi_dec_t d;
    d = '{kind: K_OTHER, lanes: four ? 3'd4 : 3'd1, has_addr: 1'b1,
          legal: 1'b1};
    case (op)
      `SFPI_OP_READ:       d.kind = K_READ;
      `SFPI_OP_DUAL_READ:  begin d.kind = K_READ; d.lanes = 3'd2;
                             d.legal = ~four; end
      `SFPI_OP_QUAD_READ:  begin d.kind = K_READ; d.lanes = 3'd4;
                             d.legal = qe; end
      `SFPI_OP_PROG:       d.kind = K_PROG;
      `SFPI_OP_QUAD_PROG:  begin d.kind = K_PROG; d.lanes = 3'd4;
                             d.legal = qe; end
      `SFPI_OP_ERASE_4K:   d.kind = K_ERASE_4K;
      `SFPI_OP_ERASE_32K:  d.kind = K_ERASE_32K;
      `SFPI_OP_ERASE_64K:  d.kind = K_ERASE_64K;
      `SFPI_OP_ERASE_CHIP: begin d.kind = K_ERASE_CHIP; d.has_addr = 1'b0;
                             end
      `SFPI_OP_WR_STATUS:  begin d.kind = K_WR_STATUS; d.has_addr = 1'b0;
                             end
      `SFPI_OP_FOUR_ON:    begin d.kind = K_MODE_ON; d.has_addr = 1'b0;
                             d.legal = qe; end
      `SFPI_OP_FOUR_OFF:   begin d.kind = K_MODE_OFF; d.has_addr = 1'b0;
                             end
      default:             d.legal = 1'b0;
    endcase
    return d;
  endfunction : f_decode

  // Shifts the sampled lanes in, most significant bit first.
  function automatic logic [23:0] f_shift(input logic [23:0] sh,
                                          input logic [3:0] io,
                                          input logic [2:0] lanes);
    case (lanes)
      3'd4:    return {sh[19:0], io};
      3'd2:    return {sh[21:0], io[1:0]};
      default: return {sh[22:0], io[0]};
    endcase
  endfunction : f_shift

  function automatic logic [3:0] f_present(input logic [7:0] b,
                                           input logic [2:0] lanes);
    case (lanes)
      3'd4:    return b[7:4];
      3'd2:    return {2'b00, b[7:6]};
      default: return {2'b00, b[7], 1'b0};
    endcase
  endfunction : f_present

  function automatic logic [3:0] f_lane_mask(input logic [2:0] lanes);
    case (lanes)
      3'd4:    return 4'hF;
      3'd2:    return 4'h3;
      default: return 4'h2;
    endcase
  endfunction : f_lane_mask

  // Erase addresses are forced onto the boundary of the erased unit.
  function automatic logic [20:0] f_erase_base(input sfpi_kind_t k,
                                               input logic [20:0] a);
    case (k)
      K_ERASE_4K:   return a & `SFPI_MASK_4K;
      K_ERASE_32K:  return a & `SFPI_MASK_32K;
      K_ERASE_64K:  return a & `SFPI_MASK_64K;
      K_ERASE_CHIP: return a & `SFPI_MASK_CHIP;
      default:      return a;
    endcase
  endfunction : f_erase_base

  // ========================================================================
  // Pin synchronisers and read-data buffer
  // The pins are oversampled, so the serial clock must stay well below a
  // quarter of sys_clk; each pin edge is seen two to three cycles late.
  sfpi_pins_t  pin_raw, pin_s;
  logic        sclk_d_ff, cs_d_ff;
  logic [7:0]  fifo_data;
  logic        fifo_valid, pop;

  assign pin_raw = '{sclk: sclk, cs_n: cs_n, io: io_in};

  sfpi_sync #(.WIDTH(6)) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in (pin_raw),
    .sync_ff  (pin_s)
  );

  sfpi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .in_data      (rd_data),
    .in_valid     (rd_valid),
    .in_ready_ff  (rd_ready_ff),
    .out_data_ff  (fifo_data),
    .out_valid_ff (fifo_valid),
    .out_ready    (pop)
  );

  // ========================================================================
  // Serial engine
  sfpi_state_t state_ff, nxt_state;
  sfpi_dec_t   dec_ff, nxt_dec, dec;
  sfpi_cmd_t   nxt_cmd;
  sfpi_wr_t    nxt_wr;
  logic [23:0] sh_ff, nxt_sh, sh_new;
  logic [20:0] addr_ff, nxt_addr;
  logic [4:0]  bitcnt_ff, nxt_bitcnt, bits;
  logic [8:0]  wcnt_ff, nxt_wcnt;
  logic [7:0]  out_sh_ff, nxt_out_sh, cur;
  logic [3:0]  ocnt_ff, nxt_ocnt, nxt_io_out, nxt_io_oe;
  logic [2:0]  lanes;
  logic        armed_ff, nxt_armed, nxt_paused, nxt_four, nxt_blocked;
  logic        nxt_cmd_valid, nxt_wr_valid, nxt_selected;
  logic        cs_hi, sclk_s, rise, fall, fall_raw, pause_req;

  always_comb begin
    cs_hi      = pin_s.cs_n;
    sclk_s     = pin_s.sclk;
    fall_raw   = sclk_d_ff & ~sclk_s;
    rise       = ~sclk_d_ff & sclk_s & ~paused_ff & ~cs_hi;
    fall       = fall_raw & ~paused_ff & ~cs_hi;
    nxt_state  = state_ff;
    nxt_dec    = dec_ff;
    nxt_sh     = sh_ff;
    nxt_addr   = addr_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_wcnt   = wcnt_ff;
    nxt_out_sh = out_sh_ff;
    nxt_ocnt   = ocnt_ff;
    nxt_io_out = io_out_ff;
    nxt_four   = four_lane_command_mode_ff & quad_enable_bit;
    nxt_armed  = armed_ff | cs_hi;
    nxt_cmd    = cmd_ff;
    nxt_cmd_valid = cmd_valid_ff & ~cmd_ready;
    nxt_wr       = wr_ff;
    nxt_wr_valid = 1'b0;
    nxt_selected = ~cs_hi;
    pop        = 1'b0;
    cur        = out_sh_ff;
    dec        = dec_ff;
    lanes      = (state_ff == ST_CMD || state_ff == ST_ADDR)
                 ? (four_lane_command_mode_ff ? 3'd4 : 3'd1)
                 : dec_ff.lanes;
    sh_new     = f_shift(sh_ff, pin_s.io, lanes);
    bits       = bitcnt_ff + {2'b00, lanes};
    // Lane 2 is only a write protect pin while lanes 2 and 3 are not data.
    nxt_blocked = status_protect_bits[1] |
                  (status_protect_bits[0] & ~pin_s.io[2] &
                   ~quad_enable_bit);
    // Lane 3 is only a pause pin under the same condition.
    pause_req  = ~cs_hi & ~pin_s.io[3] & ~quad_enable_bit;
    nxt_paused = paused_ff;
    if (cs_hi || quad_enable_bit) begin
      nxt_paused = 1'b0;
    end else if (pause_req != paused_ff && (~sclk_s || fall_raw)) begin
      nxt_paused = pause_req;
    end

    // A command already handed off stays valid here; only the shifter is
    // dropped when the host deselects.
    if (cs_hi) begin
      nxt_state  = ST_IDLE;
      nxt_bitcnt = '0;
      nxt_ocnt   = '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (cs_d_ff && armed_ff) begin
            nxt_state  = ST_CMD;
            nxt_bitcnt = '0;
          end
        end
        ST_CMD: begin
          if (rise) begin
            nxt_sh     = sh_new;
            nxt_bitcnt = bits;
            if (bits == `SFPI_BYTE_BITS) begin
              dec        = f_decode(sh_new[7:0], quad_enable_bit,
                                    four_lane_command_mode_ff);
              nxt_dec    = dec;
              nxt_bitcnt = '0;
              nxt_wcnt   = '0;
              nxt_addr   = '0;
              nxt_cmd    = '{kind: dec.kind, opcode: sh_new[7:0],
                             addr: '0, lanes: dec.lanes};
              nxt_state  = ST_IGNORE;
              if (!dec.legal) begin
                nxt_state = ST_IGNORE;
              end else if (dec.kind == K_MODE_ON) begin
                nxt_four  = 1'b1;
              end else if (dec.kind == K_MODE_OFF) begin
                nxt_four  = 1'b0;
              end else if (dec.kind == K_WR_STATUS) begin
                nxt_state = status_write_blocked_ff ? ST_IGNORE
                                                    : ST_WDATA;
              end else if (dec.has_addr) begin
                nxt_state = ST_ADDR;
              end else begin
                nxt_cmd_valid = 1'b1;
              end
            end
          end
        end
        ST_ADDR: begin
          if (rise) begin
            nxt_sh     = sh_new;
            nxt_bitcnt = bits;
            if (bits == `SFPI_ADDR_BITS) begin
              nxt_bitcnt    = '0;
              nxt_addr      = f_erase_base(dec_ff.kind, sh_new[20:0]);
              nxt_cmd.addr  = nxt_addr;
              nxt_cmd_valid = 1'b1;
              case (dec_ff.kind)
                K_READ:  nxt_state = ST_RDATA;
                K_PROG:  nxt_state = ST_WDATA;
                default: nxt_state = ST_IGNORE;
              endcase
            end
          end
        end
        ST_WDATA: begin
          if (rise) begin
            nxt_sh     = sh_new;
            nxt_bitcnt = bits;
            if (bits == `SFPI_BYTE_BITS) begin
              nxt_bitcnt = '0;
              if (wcnt_ff < `SFPI_PAGE_BYTES) begin
                nxt_wr_valid = 1'b1;
                nxt_wcnt     = wcnt_ff + 9'h001;
                nxt_wr = '{data: sh_new[7:0], clear_mask: ~sh_new[7:0],
                           offset: addr_ff[7:0] + wcnt_ff[7:0]};
              end
            end
          end
        end
        ST_RDATA: begin
          if (fall) begin
            if (ocnt_ff == 4'h0) begin
              cur = fifo_valid ? fifo_data : `SFPI_RD_FILL;
              pop = fifo_valid;
            end
            nxt_io_out = f_present(cur, dec_ff.lanes);
            nxt_out_sh = cur << dec_ff.lanes;
            nxt_ocnt   = ocnt_ff + {1'b0, dec_ff.lanes};
            if (nxt_ocnt == 4'h8) begin
              nxt_ocnt = 4'h0;
            end
          end
        end
        default: ;
      endcase
    end
    nxt_io_oe = (nxt_state == ST_RDATA && !nxt_paused)
                ? f_lane_mask(dec_ff.lanes) : 4'h0;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff  <= ST_IDLE;
      dec_ff    <= '{kind: K_OTHER, lanes: 3'd1, has_addr: 1'b0,
                     legal: 1'b0};
      sh_ff     <= '0;
      addr_ff   <= '0;
      bitcnt_ff <= '0;
      wcnt_ff   <= '0;
      out_sh_ff <= '0;
      ocnt_ff   <= '0;
      sclk_d_ff <= 1'b1;
      cs_d_ff   <= 1'b1;
      armed_ff  <= 1'b0;
      io_out_ff <= 4'h0;
      io_oe_ff  <= 4'h0;
      cmd_ff    <= '{kind: K_OTHER, opcode: 8'h00, addr: '0, lanes: 3'd1};
      cmd_valid_ff <= 1'b0;
      wr_ff        <= '0;
      wr_valid_ff  <= 1'b0;
      selected_ff  <= 1'b0;
      paused_ff    <= 1'b0;
      four_lane_command_mode_ff <= 1'b0;
      status_write_blocked_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      dec_ff    <= nxt_dec;
      sh_ff     <= nxt_sh;
      addr_ff   <= nxt_addr;
      bitcnt_ff <= nxt_bitcnt;
      wcnt_ff   <= nxt_wcnt;
      out_sh_ff <= nxt_out_sh;
      ocnt_ff   <= nxt_ocnt;
      sclk_d_ff <= sclk_s;
      cs_d_ff   <= cs_hi;
      armed_ff  <= nxt_armed;
      io_out_ff <= nxt_io_out;
      io_oe_ff  <= nxt_io_oe;
      cmd_ff    <= nxt_cmd;
      cmd_valid_ff <= nxt_cmd_valid;
      wr_ff        <= nxt_wr;
      wr_valid_ff  <= nxt_wr_valid;
      selected_ff  <= nxt_selected;
      paused_ff    <= nxt_paused;
      four_lane_command_mode_ff <= nxt_four;
      status_write_blocked_ff   <= nxt_blocked;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_cmd_rise_single;
    state_ff == ST_CMD && rise && !four_lane_command_mode_ff;
  endsequence

  chk_serial_sample: assert property (s_cmd_rise_single |=>
      sh_ff[0] == $past(pin_s.io[0]))
    else $error("command bit not taken from serial_in on rise");
  chk_out_on_fall: assert property ($changed(io_out_ff) |->
      $past(fall))
    else $error("read data changed away from a clock fall");
  chk_desel_release: assert property (cs_hi |=> io_oe_ff == 4'h0)
    else $error("lanes driven while deselected");
  chk_pause_release: assert property (paused_ff |-> io_oe_ff == 4'h0)
    else $error("lanes driven during pause");
  chk_pause_quad: assert property (quad_enable_bit |=> !paused_ff)
    else $error("pause active with quad enable set");
  chk_unarmed_idle: assert property (!armed_ff |=> state_ff == ST_IDLE)
    else $error("instruction taken before chip select edge");
  chk_four_lane_qe: assert property (!quad_enable_bit |=>
      !four_lane_command_mode_ff)
    else $error("four-lane mode without quad enable");
  chk_wp_block: assert property ((status_protect_bits[0] && !pin_s.io[2]
      && !quad_enable_bit) |=> status_write_blocked_ff)
    else $error("write protect failed to block status write");
  chk_page_limit: assert property (wr_valid_ff |->
      wcnt_ff <= `SFPI_PAGE_BYTES && wcnt_ff != 9'h000)
    else $error("more than one page of program data");
  chk_erase_align: assert property ((cmd_valid_ff &&
      cmd_ff.kind == K_ERASE_4K) |-> cmd_ff.addr[11:0] == 12'h000)
    else $error("sector erase address not aligned");
  chk_cmd_hold: assert property ((cmd_valid_ff && !cmd_ready) |=>
      cmd_valid_ff && $stable(cmd_ff.kind))
    else $error("pending command dropped");

endmodule : sfpi_top

`default_nettype wire

// [dv/sfpi_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bus master model
module sfpi_host (
  // Clock.
  input  wire logic [0:0] sys_clk,
  // Device lanes.
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe,
  // Pins.
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      io_in
);
  logic [3:0] h = 4'hF;
  logic       idle_hi = 1'b0;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // Lanes the device enables carry its value; the rest carry ours.
  assign io_in = (io_oe & io_out) | (~io_oe & h);
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  // Each bit opens with a clock fall, which launches read data, and ends
  // with the rise at which both sides sample; this suits modes 0 and 3.
  task automatic xb(input logic [7:0] w, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sclk <= 1'b0;
      h[0] <= w[i];
      h[1] <= ~h[1];
      wt(5);
      sclk <= 1'b1;
      r[i] = io_out[1];
      wt(5);
    end
  endtask : xb
  // The clock is parked at its idle level before chip select moves.
  task automatic sel(input logic v);
    sclk <= idle_hi;
    wt(5);
    cs_n <= v;
    wt(5);
  endtask : sel
  task automatic tick(input logic v);
    sclk <= v;
    wt(6);
  endtask : tick
endmodule : sfpi_host
`default_nettype wire

// [dv/sfpi_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench
module sfpi_top_tb_top;
  import sfpi_pkg::*;
  logic       sys_clk = 0, reset, quad_enable_bit, cmd_ready;
  logic       rd_valid, sclk, cs_n, cmd_valid_ff, wr_valid_ff;
  logic       rd_ready_ff, selected_ff, paused_ff, status_write_blocked_ff;
  logic       four_lane_command_mode_ff;
  logic [1:0] status_protect_bits;
  logic [7:0] rd_data, r;
  logic [3:0] io_in, io_out_ff, io_oe_ff;
  sfpi_cmd_t  cmd_ff;
  sfpi_wr_t   wr_ff, wl;
  int         fail_count = 0, n_tests = 0, cyc = 0, nw = 0, n = 0;
  logic [7:0] eop[4] = '{8'h20, 8'h52, 8'hD8, 8'hC7};
  sfpi_kind_t ek[4] = '{K_ERASE_4K, K_ERASE_32K, K_ERASE_64K, K_ERASE_CHIP};
  logic [20:0] ea[4] = '{21'h1FF000, 21'h1F8000, 21'h1F0000, 21'h000000};
  always #12.5 sys_clk = ~sys_clk;
  sfpi_top uut (.sys_clk, .reset, .sclk, .cs_n, .io_in, .io_out_ff,
    .io_oe_ff, .quad_enable_bit, .status_protect_bits, .cmd_ff,
    .cmd_valid_ff, .cmd_ready, .wr_ff, .wr_valid_ff, .rd_data, .rd_valid,
    .rd_ready_ff, .selected_ff, .paused_ff, .four_lane_command_mode_ff,
    .status_write_blocked_ff);
  sfpi_host host (.sys_clk, .io_out(io_out_ff), .io_oe(io_oe_ff), .sclk,
    .cs_n, .io_in);
  task automatic stop_test;
    $display("Compares %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  // Written bytes are one-cycle pulses, so they are caught here.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (wr_valid_ff) begin
      wl <= wr_ff;
      nw <= nw + 1;
    end
    if (cyc == 30000) begin
      fail_count++;
      stop_test;
    end
  end
  task automatic cmp(input logic [39:0] g, input logic [39:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic fr(input logic [7:0] op, input logic [23:0] a);
    host.sel(1'b0);
    host.xb(op, r);
    host.xb(a[23:16], r);
    host.xb(a[15:8], r);
    host.xb(a[7:0], r);
  endtask : fr
  task automatic chk_cmd(sfpi_kind_t k, logic [20:0] a, logic [2:0] l);
    cmp({cmd_valid_ff, cmd_ff.kind, cmd_ff.addr, cmd_ff.lanes},
        {1'b1, k, a, l});
    cmd_ready <= 1'b1;
    @(posedge sys_clk);
    cmd_ready <= 1'b0;
    @(posedge sys_clk);
    cmp(cmd_valid_ff, 0);
  endtask : chk_cmd
  initial begin
    reset               = 1'b1;
    quad_enable_bit     = 1'b0;
    cmd_ready           = 1'b0;
    rd_valid            = 1'b0;
    rd_data             = 8'h00;
    status_protect_bits = 2'b00;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd_valid <= 1'b1;
    rd_data  <= 8'h10;
    repeat (8) begin
      @(posedge sys_clk);
      if (rd_ready_ff) n++;
      rd_data <= 8'h10 + n[7:0];
    end
    rd_valid <= 1'b0;
    cmp({rd_ready_ff, 1'(n >= 4)}, 2'b01);
    fr(8'h03, 24'h012345);
    chk_cmd(K_READ, 21'h012345, 3'h1);
    for (int j = 0; j < n; j++) begin
      host.xb(8'h00, r);
      cmp({r, io_oe_ff}, {8'h10 + j[7:0], 4'h2});
      if (j == 0) begin
        host.h[3] <= 1'b0;
        host.wt(6);
        cmp(paused_ff, 0);
        host.tick(1'b0);
        host.tick(1'b1);
        host.tick(1'b0);
        cmp({selected_ff, paused_ff, io_oe_ff}, 6'h30);
        host.h[3] <= 1'b1;
        host.wt(6);
      end
    end
    host.xb(8'h00, r);
    cmp(r, 8'hFF);
    host.sel(1'b1);
    cmp({selected_ff, io_oe_ff}, 0);
    host.idle_hi = 1'b1;
    for (int k = 0; k < 4; k++) begin
      fr(eop[k], 24'h1FF123);
      chk_cmd(ek[k], ea[k], 3'h1);
      host.sel(1'b1);
    end
    host.idle_hi = 1'b0;
    fr(8'h6B, 24'h000040);
    host.sel(1'b1);
    cmp(cmd_valid_ff, 0);
    quad_enable_bit <= 1'b1;
    fr(8'h6B, 24'h000040);
    chk_cmd(K_READ, 21'h000040, 3'h4);
    host.sel(1'b1);
    host.sel(1'b0);
    host.xb(8'h38, r);
    cmp(four_lane_command_mode_ff, 1);
    host.sel(1'b1);
    quad_enable_bit <= 1'b0;
    host.wt(2);
    cmp(four_lane_command_mode_ff, 0);
    fr(8'h02, 24'h0000FE);
    chk_cmd(K_PROG, 21'h0000FE, 3'h1);
    host.xb(8'h5A, r);
    cmp({wl, 8'(nw)}, {24'h5AA5FE, 8'h01});
    host.xb(8'h81, r);
    cmp({wl, 8'(nw)}, {24'h817EFF, 8'h02});
    host.sel(1'b1);
    // Lock bit, unprotected, write protect pin low, then the pin as lane 2.
    for (int b = 0; b < 4; b++) begin
      status_protect_bits <= (b == 0) ? 2'b10 : (b == 1) ? 2'b00 : 2'b01;
      host.h[2] <= (b < 2);
      quad_enable_bit <= (b == 3);
      host.sel(1'b0);
      host.xb(8'h01, r);
      host.xb(8'h02, r);
      cmp({status_write_blocked_ff, 8'(nw)},
          {!b[0], 8'(2 + (b > 0) + (b > 2))});
      cmp(wl, b ? 24'h02FD00 : 24'h817EFF);
      host.sel(1'b1);
    end
    stop_test;
  end
endmodule : sfpi_top_tb_top
`default_nettype wire
